//--- hw/dsf_device.sv
// Purpose: device end, decodes seek and set-features commands
// Assumes: host sends one command at a time and waits for done
// Notes: seek duration is a fixed model count
`timescale 1ns/1ps
module dsf_device (
   input  wire logic  clk_sys_in,          // 25 MHz clock
   input  wire logic  resetn_in,           // async reset, active low
   dsf_if.device      tf,                  // task-file link
   input  wire logic  reassign_full_in,    // reassignment capacity reached
   output logic       write_cache_out,     // actual write cache state
   output logic       look_ahead_out,      // read look-ahead enabled
   output logic       revert_out,          // revert to power-on defaults
   output logic       release_irq_out,     // release interrupt enabled
   output logic       apm_en_out,          // power management enabled
   output logic [7:0] apm_level_out,       // power management level
   output logic       puis_out,            // power-up in standby enabled
   output logic       spinup_out,          // spin-up request pulse
   output logic [7:0] sata_opts_out,       // sata options
   output logic [4:0] xfer_type_out,       // transfer type
   output logic [2:0] xfer_mode_out,       // transfer mode number
   output logic       pio_flow_control_signal_out, // pio flow control in use
   output logic [31:0] sector_time_out,    // host sector times
   output logic [15:0] ident_w85_out,      // identify word 85
   output logic [15:0] ident_w129_out      // identify word 129
);
   dsf_pkg::dsf_dev_e st_q, st_d;
   logic [7:0]  cnt_q, cnt_d;
   logic        wc_req_q, wc_req_d;
   logic        rla_q, rla_d, rev_q, rev_d, apm_q, apm_d, puis_q, puis_d, spin_q, spin_d;
   logic [7:0]  lvl_q, lvl_d, sata_q, sata_d, stat_q, stat_d, err_q, err_d;
   logic [4:0]  xt_q, xt_d;
   logic [2:0]  xm_q, xm_d;
   logic        nordy_q, nordy_d, done_q, done_d, bad_q, bad_d;
   logic [31:0] stime_q, stime_d;
   logic [7:0]  rsn_q, rsn_d, rcl_q, rcl_d, rch_q, rch_d, rhd_q, rhd_d;
   logic        wc_eff, xfer_ok, abort, lba, wc_out_q;
   assign wc_eff = wc_req_q & ~reassign_full_in; // R19
   assign lba = tf.drive_head_select[dsf_pkg::DH_LBA];
   always_comb begin
      unique case (tf.sector_count[7:3]) // R17 R18
         dsf_pkg::XT_PIO_DEF: xfer_ok = tf.sector_count[2:0] <= dsf_pkg::XM_PIO_NORDY;
         dsf_pkg::XT_PIO_FC:  xfer_ok = tf.sector_count[2:0] <= dsf_pkg::XM_PIO_MAX;
         dsf_pkg::XT_MWDMA:   xfer_ok = tf.sector_count[2:0] <= dsf_pkg::XM_MW_MAX;
         dsf_pkg::XT_UDMA:    xfer_ok = tf.sector_count[2:0] <= dsf_pkg::XM_UDMA_MAX;
         default:             xfer_ok = 1'b0;
      endcase
   end
   always_comb begin
      st_d = st_q; cnt_d = cnt_q; wc_req_d = wc_req_q; rla_d = rla_q; rev_d = rev_q;
      apm_d = apm_q; lvl_d = lvl_q; puis_d = puis_q; spin_d = 1'b0; sata_d = sata_q;
      xt_d = xt_q; xm_d = xm_q; nordy_d = nordy_q; stime_d = stime_q;
      stat_d = stat_q; err_d = err_q; done_d = 1'b0; bad_d = bad_q;
      rsn_d = rsn_q; rcl_d = rcl_q; rch_d = rch_q; rhd_d = rhd_q;
      abort = 1'b0;
      unique case (st_q)
         dsf_pkg::DS_IDLE: begin
            if (tf.cmd_valid && tf.command[7:4] == dsf_pkg::CMD_SEEK_HI) begin // R1 R2
               st_d = dsf_pkg::DS_SEEK;
               cnt_d = dsf_pkg::SEEK_CYCLES;
               stat_d = 8'h00;
               stat_d[dsf_pkg::ST_BSY] = 1'b1;
               err_d = 8'h00;
               // R3 R4
               if (lba) begin
                  bad_d = {tf.drive_head_select[3:0], tf.cyl_high, tf.cyl_low,
                           tf.sector_number} > dsf_pkg::LBA_LIMIT;
               end else begin
                  bad_d = {tf.cyl_high, tf.cyl_low} > dsf_pkg::CYL_LIMIT;
               end
               rsn_d = tf.sector_number; // R5
               rcl_d = tf.cyl_low;
               rch_d = tf.cyl_high;
               rhd_d = {4'h0, tf.drive_head_select[3:0]};
            end else if (tf.cmd_valid && tf.command == dsf_pkg::CMD_SET_FEAT) begin // R6
               unique case (tf.feature)
                  dsf_pkg::F_WC_ON:      wc_req_d = 1'b1; // R8
                  dsf_pkg::F_WC_OFF:     wc_req_d = 1'b0; // R8
                  dsf_pkg::F_XFER: begin // R9
                     if (xfer_ok) begin
                        xt_d = tf.sector_count[7:3];
                        xm_d = tf.sector_count[2:0];
                        nordy_d = tf.sector_count[7:3] == dsf_pkg::XT_PIO_DEF &&
                                  tf.sector_count[2:0] == dsf_pkg::XM_PIO_NORDY;
                     end else begin
                        abort = 1'b1;
                     end
                  end
                  dsf_pkg::F_APM_ON: begin // R10 R22
                     if (tf.sector_count == dsf_pkg::APM_BAD_LO ||
                         tf.sector_count == dsf_pkg::APM_BAD_HI) begin
                        abort = 1'b1;
                     end else begin
                        apm_d = 1'b1;
                        lvl_d = tf.sector_count;
                     end
                  end
                  dsf_pkg::F_APM_OFF:    apm_d = 1'b0; // R10
                  dsf_pkg::F_PUIS_ON:    puis_d = 1'b1; // R11
                  dsf_pkg::F_PUIS_OFF:   puis_d = 1'b0; // R11
                  dsf_pkg::F_SPINUP:     spin_d = 1'b1; // R11
                  dsf_pkg::F_SATA_ON:    sata_d[tf.sector_count[2:0]] = 1'b1; // R12 R21
                  dsf_pkg::F_SATA_OFF:   sata_d[tf.sector_count[2:0]] = 1'b0; // R12 R21
                  dsf_pkg::F_SECT_TIME:  stime_d = {tf.cyl_high, tf.cyl_low,
                                                    tf.sector_number, tf.sector_count}; // R13
                  dsf_pkg::F_RLA_OFF:    rla_d = 1'b0; // R14
                  dsf_pkg::F_RLA_ON:     rla_d = 1'b1; // R14
                  dsf_pkg::F_REVERT_OFF: rev_d = 1'b0; // R15
                  dsf_pkg::F_REVERT_ON:  rev_d = 1'b1; // R15
                  default:               abort = 1'b1; // R7
               endcase
               st_d = dsf_pkg::DS_DONE;
               stat_d = dsf_pkg::STATUS_IDLE; // R23
               stat_d[dsf_pkg::ST_ERR] = abort;
               err_d = 8'h00;
               err_d[dsf_pkg::ER_ABT] = abort; // R7
            end
         end
         dsf_pkg::DS_SEEK: begin
            cnt_d = cnt_q - 8'h01;
            if (cnt_q == 8'h01) begin
               st_d = dsf_pkg::DS_DONE;
               stat_d = dsf_pkg::STATUS_IDLE; // R23 R24
               stat_d[dsf_pkg::ST_DSC] = ~bad_q; // R24
               stat_d[dsf_pkg::ST_ERR] = bad_q;
               err_d[dsf_pkg::ER_IDN] = bad_q; // R24
            end
         end
         dsf_pkg::DS_DONE: begin
            done_d = 1'b1;
            st_d = dsf_pkg::DS_IDLE;
         end
         default: st_d = dsf_pkg::DS_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q <= dsf_pkg::DS_IDLE; cnt_q <= 8'h00;
         wc_req_q <= 1'b1; rla_q <= 1'b1; rev_q <= 1'b0; // R16
         apm_q <= 1'b0; lvl_q <= 8'h00; puis_q <= 1'b0; spin_q <= 1'b0; sata_q <= 8'h00;
         xt_q <= 5'h00; xm_q <= 3'h0; nordy_q <= 1'b0; stime_q <= 32'h0000_0000;
         stat_q <= dsf_pkg::STATUS_IDLE; err_q <= 8'h00; done_q <= 1'b0; bad_q <= 1'b0;
         rsn_q <= 8'h00; rcl_q <= 8'h00; rch_q <= 8'h00; rhd_q <= 8'h00;
         wc_out_q <= 1'b1;
      end else begin
         st_q <= st_d; cnt_q <= cnt_d; wc_req_q <= wc_req_d; rla_q <= rla_d; rev_q <= rev_d;
         apm_q <= apm_d; lvl_q <= lvl_d; puis_q <= puis_d; spin_q <= spin_d; sata_q <= sata_d;
         xt_q <= xt_d; xm_q <= xm_d; nordy_q <= nordy_d; stime_q <= stime_d;
         stat_q <= stat_d; err_q <= err_d; done_q <= done_d; bad_q <= bad_d;
         rsn_q <= rsn_d; rcl_q <= rcl_d; rch_q <= rch_d; rhd_q <= rhd_d;
         wc_out_q <= wc_eff; // R19 R20
      end
   end
   assign tf.done = done_q;
   assign tf.device_status = stat_q;
   assign tf.error_report = err_q;
   assign tf.ret_sector_number = rsn_q;
   assign tf.ret_cyl_low = rcl_q;
   assign tf.ret_cyl_high = rch_q;
   assign tf.ret_head = rhd_q;
   assign write_cache_out = wc_out_q;
   assign look_ahead_out = rla_q;
   assign revert_out = rev_q;
   assign release_irq_out = 1'b0;
   assign apm_en_out = apm_q;
   assign apm_level_out = lvl_q;
   assign puis_out = puis_q;
   assign spinup_out = spin_q;
   assign sata_opts_out = sata_q;
   assign xfer_type_out = xt_q;
   assign xfer_mode_out = xm_q;
   assign pio_flow_control_signal_out = ~nordy_q;
   assign sector_time_out = stime_q;
   assign ident_w85_out = {10'h000, wc_out_q, 5'h00}; // R20
   assign ident_w129_out = {15'h0000, wc_out_q}; // R20
endmodule

//--- hw/dsf_pkg.sv
// Purpose: shared constants for the seek / set-features command decoder
// Assumes: task-file registers are 8 bits; device holds state, host issues commands
// Notes: How it works list below
// How it works
// R1 - command 0111xxxx starts a seek
// R2 - seek runs even on unformatted medium
// R3 - host puts address in sector/cylinder registers
// R4 - host puts head or address 24-27 in head bits
// R5 - device reports current address after LBA seek
// R6 - command EFh selects feature; bits 7,5 set
// R7 - unknown feature value aborts with error
// R8 - 02h cache on, 82h cache off
// R9 - 03h loads transfer mode from sector count
// R10 - 05h power management on, 85h off
// R11 - 06h/86h standby power-up, 07h spin-up
// R12 - 10h/90h Serial ATA option on/off
// R13 - 43h records host sector time
// R14 - 55h look-ahead off, AAh on
// R15 - 66h revert off, CCh on
// R16 - reset defaults: cache, look-ahead on, others off
// R17 - sector count: type upper five, mode lower three
// R18 - decode PIO, flow control, multiword, ultra modes
// R19 - reassign capacity reached forces cache off
// R20 - actual cache state shown in identify words
// R21 - sector count selects Serial ATA option
// R22 - power level 00h or FFh aborts
// R23 - completion clears busy, sets ready, error
// R24 - seek complete flag; bad target sets not-found
package dsf_pkg;
   localparam logic [3:0] CMD_SEEK_HI   = 4'h7;
   localparam logic [7:0] CMD_SET_FEAT  = 8'hEF;
   localparam logic [7:0] F_WC_ON       = 8'h02;
   localparam logic [7:0] F_XFER        = 8'h03;
   localparam logic [7:0] F_APM_ON      = 8'h05;
   localparam logic [7:0] F_PUIS_ON     = 8'h06;
   localparam logic [7:0] F_SPINUP      = 8'h07;
   localparam logic [7:0] F_SATA_ON     = 8'h10;
   localparam logic [7:0] F_SECT_TIME   = 8'h43;
   localparam logic [7:0] F_RLA_OFF     = 8'h55;
   localparam logic [7:0] F_REVERT_OFF  = 8'h66;
   localparam logic [7:0] F_WC_OFF      = 8'h82;
   localparam logic [7:0] F_APM_OFF     = 8'h85;
   localparam logic [7:0] F_PUIS_OFF    = 8'h86;
   localparam logic [7:0] F_SATA_OFF    = 8'h90;
   localparam logic [7:0] F_RLA_ON      = 8'hAA;
   localparam logic [7:0] F_REVERT_ON   = 8'hCC;
   localparam logic [7:0] APM_BAD_LO    = 8'h00;
   localparam logic [7:0] APM_BAD_HI    = 8'hFF;
   localparam logic [4:0] XT_PIO_DEF    = 5'h00;
   localparam logic [4:0] XT_PIO_FC     = 5'h01;
   localparam logic [4:0] XT_MWDMA      = 5'h04;
   localparam logic [4:0] XT_UDMA       = 5'h08;
   localparam logic [2:0] XM_PIO_MAX    = 3'h4;
   localparam logic [2:0] XM_MW_MAX     = 3'h2;
   localparam logic [2:0] XM_UDMA_MAX   = 3'h6;
   localparam logic [2:0] XM_PIO_NORDY  = 3'h1;
   // status bits
   localparam int ST_BSY = 7;
   localparam int ST_RDY = 6;
   localparam int ST_DSC = 4;
   localparam int ST_DRQ = 3;
   localparam int ST_ERR = 0;
   // error bits
   localparam int ER_IDN = 4;
   localparam int ER_ABT = 2;
   // device/head fields
   localparam int DH_LBA = 6;
   localparam logic [7:0] DH_FIXED = 8'hA0;
   localparam logic [7:0] STATUS_IDLE = 8'h50;
   // seek time in device clocks, arbitrary model
   localparam logic [7:0] SEEK_CYCLES = 8'h10;
   // highest reachable lba / cylinder, arbitrary model limits
   localparam logic [27:0] LBA_LIMIT  = 28'h0FF_FFFF;
   localparam logic [15:0] CYL_LIMIT  = 16'h3FFF;
   // host apb register offsets
   localparam logic [7:0] A_CMD     = 8'h00;
   localparam logic [7:0] A_FEAT    = 8'h04;
   localparam logic [7:0] A_SCNT    = 8'h08;
   localparam logic [7:0] A_SNUM    = 8'h0C;
   localparam logic [7:0] A_CYL     = 8'h10;
   localparam logic [7:0] A_DHEAD   = 8'h14;
   localparam logic [7:0] A_RESULT  = 8'h18;
   localparam logic [7:0] A_RETADDR = 8'h1C;
   typedef enum logic [1:0] {
      DS_IDLE = 2'b00,
      DS_SEEK = 2'b01,
      DS_DONE = 2'b10
   } dsf_dev_e;
   typedef enum logic [1:0] {
      HS_IDLE = 2'b00,
      HS_WAIT = 2'b01,
      HS_CAPT = 2'b10
   } dsf_host_e;
endpackage

//--- hw/dsf_if.sv
// Purpose: task-file link between host controller and device
// Assumes: single clock, signals synchronous
// Notes: cmd_valid is a one-cycle strobe with all registers valid
`timescale 1ns/1ps
interface dsf_if;
   logic       cmd_valid;
   logic [7:0] command;
   logic [7:0] feature;
   logic [7:0] sector_count;
   logic [7:0] sector_number;
   logic [7:0] cyl_low;
   logic [7:0] cyl_high;
   logic [7:0] drive_head_select;
   logic       done;
   logic [7:0] device_status;
   logic [7:0] error_report;
   logic [7:0] ret_sector_number;
   logic [7:0] ret_cyl_low;
   logic [7:0] ret_cyl_high;
   logic [7:0] ret_head;
   modport host (output cmd_valid, command, feature, sector_count, sector_number,
                 cyl_low, cyl_high, drive_head_select,
                 input done, device_status, error_report, ret_sector_number,
                 ret_cyl_low, ret_cyl_high, ret_head);
   modport device (input cmd_valid, command, feature, sector_count, sector_number,
                   cyl_low, cyl_high, drive_head_select,
                   output done, device_status, error_report, ret_sector_number,
                   ret_cyl_low, ret_cyl_high, ret_head);
endinterface

//--- hw/dsf_host.sv
// Purpose: host end, issues task-file commands ordered over apb
// Assumes: software writes registers, then the command register to launch
// Notes: result register shows busy, status and error
`timescale 1ns/1ps
module dsf_host (
   input  wire logic         clk_sys_in,   // 25 MHz clock
   input  wire logic         resetn_in,    // async reset, active low
   dsf_if.host               tf,           // task-file link
   input  wire logic         psel_in,      // apb select
   input  wire logic         penable_in,   // apb enable
   input  wire logic         pwrite_in,    // apb write
   input  wire logic [7:0]   paddr_in,     // apb byte address
   input  wire logic [31:0]  pwdata_in,    // apb write data
   output logic              pready_out,   // apb ready
   output logic [31:0]       prdata_out,   // apb read data
   output logic              pslverr_out   // apb error
);
   dsf_pkg::dsf_host_e st_q, st_d;
   logic [7:0]  cmd_q, cmd_d, ft_q, ft_d, sc_q, sc_d, sn_q, sn_d, dh_q, dh_d;
   logic [15:0] cyl_q, cyl_d;
   logic        go_q, go_d, rdy_q, rdy_d, err_q, err_d;
   logic [7:0]  rst_q, rst_d, rer_q, rer_d;
   logic [31:0] rad_q, rad_d, rd_q, rd_d;
   logic        acc;
   assign acc = psel_in & penable_in & ~rdy_q;
   always_comb begin
      st_d = st_q; cmd_d = cmd_q; ft_d = ft_q; sc_d = sc_q; sn_d = sn_q; dh_d = dh_q;
      cyl_d = cyl_q; go_d = 1'b0; rst_d = rst_q; rer_d = rer_q; rad_d = rad_q;
      rdy_d = acc; err_d = 1'b0; rd_d = 32'h0000_0000;
      if (acc && pwrite_in) begin
         unique case (paddr_in)
            dsf_pkg::A_CMD: begin
               if (st_q == dsf_pkg::HS_IDLE) begin
                  cmd_d = pwdata_in[7:0];
                  go_d = 1'b1;
                  st_d = dsf_pkg::HS_WAIT;
               end else begin
                  err_d = 1'b1;
               end
            end
            dsf_pkg::A_FEAT:  ft_d = pwdata_in[7:0];
            dsf_pkg::A_SCNT:  sc_d = pwdata_in[7:0];
            dsf_pkg::A_SNUM:  sn_d = pwdata_in[7:0];
            dsf_pkg::A_CYL:   cyl_d = pwdata_in[15:0];
            dsf_pkg::A_DHEAD: dh_d = pwdata_in[7:0] | dsf_pkg::DH_FIXED; // R6
            default:          err_d = 1'b1;
         endcase
      end else if (acc) begin
         unique case (paddr_in)
            dsf_pkg::A_CMD:     rd_d = 32'(cmd_q);
            dsf_pkg::A_FEAT:    rd_d = 32'(ft_q);
            dsf_pkg::A_SCNT:    rd_d = 32'(sc_q);
            dsf_pkg::A_SNUM:    rd_d = 32'(sn_q);
            dsf_pkg::A_CYL:     rd_d = 32'(cyl_q);
            dsf_pkg::A_DHEAD:   rd_d = 32'(dh_q);
            dsf_pkg::A_RESULT:  rd_d = {15'h0000, st_q != dsf_pkg::HS_IDLE, rer_q, rst_q};
            dsf_pkg::A_RETADDR: rd_d = rad_q;
            default:            err_d = 1'b1;
         endcase
      end
      unique case (st_q)
         dsf_pkg::HS_IDLE: ;
         dsf_pkg::HS_WAIT: if (tf.done) st_d = dsf_pkg::HS_CAPT;
         dsf_pkg::HS_CAPT: begin
            rst_d = tf.device_status;
            rer_d = tf.error_report;
            rad_d = {tf.ret_head, tf.ret_cyl_high, tf.ret_cyl_low, tf.ret_sector_number};
            st_d = dsf_pkg::HS_IDLE;
         end
         default: st_d = dsf_pkg::HS_IDLE;
      endcase
   end
   always_ff @(posedge clk_sys_in or negedge resetn_in) begin
      if (!resetn_in) begin
         st_q <= dsf_pkg::HS_IDLE; cmd_q <= 8'h00; ft_q <= 8'h00; sc_q <= 8'h00;
         sn_q <= 8'h00; dh_q <= dsf_pkg::DH_FIXED; cyl_q <= 16'h0000; go_q <= 1'b0;
         rst_q <= 8'h00; rer_q <= 8'h00; rad_q <= 32'h0000_0000;
         rdy_q <= 1'b0; err_q <= 1'b0; rd_q <= 32'h0000_0000;
      end else begin
         st_q <= st_d; cmd_q <= cmd_d; ft_q <= ft_d; sc_q <= sc_d; sn_q <= sn_d;
         dh_q <= dh_d; cyl_q <= cyl_d; go_q <= go_d; rst_q <= rst_d; rer_q <= rer_d;
         rad_q <= rad_d; rdy_q <= rdy_d; err_q <= err_d; rd_q <= rd_d;
      end
   end
   // R1 R3 R4
   assign tf.cmd_valid = go_q;
   assign tf.command = cmd_q;
   assign tf.feature = ft_q;
   assign tf.sector_count = sc_q; // R17
   assign tf.sector_number = sn_q;
   assign tf.cyl_low = cyl_q[7:0];
   assign tf.cyl_high = cyl_q[15:8];
   assign tf.drive_head_select = dh_q;
   assign pready_out = rdy_q;
   assign prdata_out = rd_q;
   assign pslverr_out = err_q;
endmodule

//--- testbench/dsf_checker.sv
// Purpose: assertions on the task-file link between host end and device end
// Assumes: one clock domain, reset active low
// Notes: no bind
`timescale 1ns/1ps
module dsf_checker (
   input  wire logic       clk_sys_in,        // clock
   input  wire logic       resetn_in,         // reset, active low
   input  wire logic       cmd_valid,         // strobe
   input  wire logic [7:0] command,           // command
   input  wire logic [7:0] feature,           // feature
   input  wire logic [7:0] sector_count,      // count
   input  wire logic [7:0] sector_number,     // lba low
   input  wire logic [7:0] cyl_low,           // lba mid
   input  wire logic [7:0] cyl_high,          // lba high
   input  wire logic [7:0] drive_head_select, // head
   input  wire logic       done,              // done
   input  wire logic [7:0] device_status,     // status
   input  wire logic [7:0] error_report,      // error
   input  wire logic [7:0] ret_sector_number, // ret low
   input  wire logic [7:0] ret_cyl_low,       // ret mid
   input  wire logic [7:0] ret_cyl_high,      // ret high
   input  wire logic [7:0] ret_head           // ret head
);
   default clocking cb @(posedge clk_sys_in); endclocking
   default disable iff (!resetn_in);
   logic       seek;
   logic       feat;
   logic       known;
   logic       far;
   logic [7:0] st;
   logic [7:0] er;
   assign seek = command[7:4] == 4'h7;
   assign feat = command == 8'hEF;
   assign st = device_status;
   assign er = error_report;
   assign known = feature inside {8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h10, 8'h43, 8'h55,
                                  8'h66, 8'h82, 8'h85, 8'h86, 8'h90, 8'hAA, 8'hCC};
   assign far = drive_head_select[6] ?
                {drive_head_select[3:0], cyl_high, cyl_low, sector_number} > 28'h0FF_FFFF :
                {cyl_high, cyl_low} > 16'h3FFF;
   sequence s_seek_go;
      cmd_valid && seek;
   endsequence
   sequence s_seek_busy;
      st[7] [*8];
   endsequence
   property p_seek_busy;
      s_seek_go |=> s_seek_busy;
   endproperty
   a_seek_busy: assert property (p_seek_busy) else $error("seek not busy");
   property p_seek_done;
      s_seek_go |-> ##[1:20] done;
   endproperty
   a_seek_done: assert property (p_seek_done) else $error("seek never done");
   property p_feat_done;
      cmd_valid && feat |-> ##[1:3] done;
   endproperty
   a_feat_done: assert property (p_feat_done) else $error("feature never done");
   property p_done_ready;
      done |-> !st[7] && st[6];
   endproperty
   a_done_ready: assert property (p_done_ready) else $error("done while busy");
   property p_bad_feat;
      done && feat && !known |-> er[2] && st[0];
   endproperty
   a_bad_feat: assert property (p_bad_feat) else $error("unknown feature kept");
   property p_apm_bad;
      done && feat && feature == 8'h05 && sector_count inside {8'h00, 8'hFF} |-> er[2] && st[0];
   endproperty
   a_apm_bad: assert property (p_apm_bad) else $error("bad level kept");
   property p_seek_far;
      done && seek && far |-> er[4] && st[0] && !st[4];
   endproperty
   a_seek_far: assert property (p_seek_far) else $error("far seek not flagged");
   property p_seek_ok;
      done && seek && !far |-> st[4] && !st[0];
   endproperty
   a_seek_ok: assert property (p_seek_ok) else $error("seek refused");
   property p_seek_ret;
      done && seek && drive_head_select[6] |-> ret_sector_number == sector_number &&
         ret_cyl_low == cyl_low && ret_cyl_high == cyl_high &&
         ret_head[3:0] == drive_head_select[3:0];
   endproperty
   a_seek_ret: assert property (p_seek_ret) else $error("address not returned");
endmodule

//--- testbench/tb_disk_seek_set_features_decoder.sv
// Purpose: drives the host end over apb and checks seek and feature results
// Assumes: host answers apb with one wait state
// Notes: random values from a fixed seed
`timescale 1ns/1ps
module tb_disk_seek_set_features_decoder;
   logic        clk_sys_in = 1'b0;
   logic        resetn_in = 1'b0;
   logic        psel = 1'b0, penable = 1'b0, pwrite = 1'b0, full = 1'b0, pready, pslverr;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rd, stime_o;
   logic        err, wc, rla, rev, apm, puis, wc_o, la_o, rv_o, ri_o, apm_o, pu_o, pf_o, su_o;
   logic [7:0]  f, sc, sn, ch, cl, dh, sata, lv_o, so_o;
   logic [4:0]  xt, xt_o;
   logic [2:0]  xm, xm_o;
   logic [15:0] w85, w129;
   logic [7:0]  tbl [16] = '{8'h02, 8'h03, 8'h05, 8'h06, 8'h07, 8'h10, 8'h43, 8'h55,
                           8'h66, 8'h82, 8'h85, 8'h86, 8'h90, 8'hAA, 8'hCC, 8'h01};
   logic [4:0]  xts [5] = '{5'h00, 5'h01, 5'h04, 5'h08, 5'h02};
   int          mismatches = 0, total_checks = 0, seed = 20807, spins = 0, nsp = 0;
   always #20 clk_sys_in = ~clk_sys_in;
   always @(posedge clk_sys_in) spins += su_o;
   dsf_if tf ();
   dsf_host i_dsf_host (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .tf(tf),
      .psel_in(psel), .penable_in(penable), .pwrite_in(pwrite), .paddr_in(paddr),
      .pwdata_in(pwdata), .pready_out(pready), .prdata_out(prdata), .pslverr_out(pslverr));
   dsf_device i_dsf_device (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .tf(tf),
      .reassign_full_in(full), .write_cache_out(wc_o), .look_ahead_out(la_o),
      .revert_out(rv_o), .release_irq_out(ri_o), .apm_en_out(apm_o), .apm_level_out(lv_o),
      .puis_out(pu_o), .spinup_out(su_o), .sata_opts_out(so_o), .xfer_type_out(xt_o),
      .xfer_mode_out(xm_o), .pio_flow_control_signal_out(pf_o), .sector_time_out(stime_o),
      .ident_w85_out(w85), .ident_w129_out(w129));
   dsf_checker i_dsf_checker (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in),
      .cmd_valid(tf.cmd_valid), .command(tf.command), .feature(tf.feature),
      .sector_count(tf.sector_count), .sector_number(tf.sector_number),
      .cyl_low(tf.cyl_low), .cyl_high(tf.cyl_high),
      .drive_head_select(tf.drive_head_select), .done(tf.done),
      .device_status(tf.device_status), .error_report(tf.error_report),
      .ret_sector_number(tf.ret_sector_number), .ret_cyl_low(tf.ret_cyl_low),
      .ret_cyl_high(tf.ret_cyl_high), .ret_head(tf.ret_head));
   task automatic report_and_stop();
      if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("ERROR %0t %s: saw %h expected %h", $time, what, seen, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk_sys_in);
      {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
      @(posedge clk_sys_in);
      penable <= 1'b1;
      n = 0;
      do begin
         @(posedge clk_sys_in);
         n++;
      end while (pready !== 1'b1 && n < 50);
      if (n >= 50) begin
         mismatches++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      {psel, penable} <= 2'b00;
   endtask
   task automatic launch(input logic [7:0] c);
      apb(1'b1, 8'h04, 32'(f));
      apb(1'b1, 8'h08, 32'(sc));
      apb(1'b1, 8'h0C, 32'(sn));
      apb(1'b1, 8'h10, {16'h0, ch, cl});
      apb(1'b1, 8'h14, 32'(dh));
      apb(1'b1, 8'h00, 32'(c));
   endtask
   task automatic finish_cmd();
      int n;
      n = 0;
      do begin
         apb(1'b0, 8'h18, 32'h0);
         n++;
      end while (rd[16] !== 1'b0 && n < 40);
      if (n >= 40) begin
         mismatches++;
         report_and_stop();
      end
   endtask
   function automatic logic is_bad(input logic [7:0] f, input logic [7:0] sc);
      if (f == 8'h05) return sc == 8'h00 || sc == 8'hFF;
      if (f == 8'h03) return !(sc[7:3] == 5'h00 && sc[2:0] <= 3'h1 ||
         sc[7:3] == 5'h01 && sc[2:0] <= 3'h4 || sc[7:3] == 5'h04 && sc[2:0] <= 3'h2 ||
         sc[7:3] == 5'h08 && sc[2:0] <= 3'h6);
      for (int k = 0; k < 15; k++) if (tbl[k] == f) return 1'b0;
      return 1'b1;
   endfunction
   initial begin
      logic bad;
      {wc, rla, rev, apm, puis, sata, xt, xm} = {5'b11000, 16'h0000};
      repeat (5) @(posedge clk_sys_in);
      resetn_in <= 1'b1;
      check({wc_o, la_o, rv_o, ri_o}, 4'b1100, "reset flags");
      apb(1'b0, 8'h18, 32'h0);
      check(rd, 32'h0000_0000, "idle result");
      apb(1'b1, 8'h14, 32'h0);
      apb(1'b0, 8'h14, 32'h0);
      check(rd[7:0], 8'hA0, "head select");
      apb(1'b0, 8'h20, 32'h0);
      check(err, 1'b1, "unmapped read");
      for (int i = 0; i < 100; i++) begin
         f = i < 32 ? tbl[i % 16] : ($random(seed) & 1) ? tbl[$unsigned($random(seed)) % 16] :
            8'($random(seed));
         sc = i < 16 ? 8'hFF : i < 32 ? 8'h01 : 8'($random(seed));
         if (i >= 32 && f == 8'h03) sc[7:3] = xts[$unsigned($random(seed)) % 5];
         {sn, ch, cl, dh} = $random(seed);
         full <= 1'($random(seed));
         launch(8'hEF);
         finish_cmd();
         bad = is_bad(f, sc);
         if (!bad) case (f)
            8'h02, 8'h82: wc = !f[7];
            8'h55, 8'hAA: rla = f[7];
            8'h66, 8'hCC: rev = f[7];
            8'h05, 8'h85: apm = !f[7];
            8'h06, 8'h86: puis = !f[7];
            8'h07: nsp++;
            8'h10, 8'h90: sata[sc[2:0]] = !f[7];
            8'h03: {xt, xm} = sc;
            default: ;
         endcase
         check(rd[15:0] & 16'h04C1, bad ? 16'h0441 : 16'h0040, "feature result");
         check(spins, nsp, "spin-up");
         check({wc_o, la_o, rv_o, ri_o, apm_o, pu_o, w85[5], w129[0]},
            {wc & ~full, rla, rev, 1'b0, apm, puis, {2{wc & ~full}}}, "flags");
         check({so_o, xt_o, xm_o}, {sata, xt, xm}, "options");
         if (f == 8'h05 && !bad) check(lv_o, sc, "power level");
         if (f == 8'h03 && !bad) check(pf_o, sc != 8'h01, "flow control");
         if (f == 8'h43) check(stime_o, {ch, cl, sn, sc}, "sector time");
      end
      for (int i = 0; i < 40; i++) begin
         {sn, ch, cl, dh} = $random(seed);
         if (i[0]) {ch[7:6], dh[3:0]} = 6'h00;
         if (i < 4) {dh[6], ch, cl} = i[1] ? 17'h0_3FFF : 17'h0_4000;
         launch(8'h70 | 8'($unsigned($random(seed)) % 8));
         if (i == 0) apb(1'b1, 8'h00, 32'h0000_0070);
         if (i == 0) check(err, 1'b1, "command while busy");
         finish_cmd();
         bad = dh[6] ? {dh[3:0], ch, cl, sn} > 28'h0FF_FFFF : {ch, cl} > 16'h3FFF;
         check(rd[15:0] & 16'h10D1, bad ? 16'h1041 : 16'h0050, "seek result");
         apb(1'b0, 8'h1C, 32'h0);
         if (dh[6]) check(rd[27:0], {dh[3:0], ch, cl, sn}, "seek address");
      end
      report_and_stop();
   end
endmodule
